// [retry_arb_map.vh]
// Register map, field positions, reset values and thresholds for the
// secondary retry limiter and arbiter enables.
// Assumes inclusion by bare name from the design files.
`ifndef RETRY_ARB_MAP_VH
`define RETRY_ARB_MAP_VH

// ----------------------------------------------------------------
// Offsets
// ----------------------------------------------------------------
`define RETRY_LIMIT_OFFSET 8'h40
`define MISC_CTRL_OFFSET 8'h44
`define RETRY_STATUS_OFFSET 8'h4C

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define RETRY_CODE_MSB 3
`define RETRY_CODE_RESET 4'h0
`define INT_ARB_EN_BIT 30
`define LINE_ARB_EN_MSB 29
`define LINE_ARB_EN_LSB 26
`define PARITY_POLICY_BIT 24
`define INT_ARB_EN_RESET 1'h1
`define LINE_ARB_EN_RESET 4'hF

// ----------------------------------------------------------------
// Retry thresholds
// ----------------------------------------------------------------
`define RETRY_LIMIT_256 32'h00000100
`define RETRY_LIMIT_64K 32'h00010000
`define RETRY_LIMIT_16M 32'h01000000
`define RETRY_LIMIT_2G 32'h80000000

`endif

// [retry_limiter.v]
// Retry limiter: counts retry terminations of the bridge's own request.
// Assumes one retry pulse per terminated attempt, and a done pulse when
// the request completes or is given up by its owner.
`timescale 1ns/10ps
`include "retry_arb_map.vh"

module retry_limiter #(
    parameter CNT_W = 32
) (
    input wire ref_clk,
    input wire resetn,
    input wire [3:0] limitCode,
    input wire reqActive,
    input wire retryPulse,
    input wire reqDone,
    output wire expirePulse,
    output wire [CNT_W-1:0] retryCount
);
    reg [CNT_W-1:0] count_q;
    reg [CNT_W-1:0] limit;
    reg expired_q;

    // ----------------------------------------------------------------
    // Threshold decode
    // ----------------------------------------------------------------
    always @* begin
        case (limitCode)
            4'h1: limit = `RETRY_LIMIT_256;
            4'h2: limit = `RETRY_LIMIT_64K;
            4'h4: limit = `RETRY_LIMIT_16M;
            4'h8: limit = `RETRY_LIMIT_2G;
            // Zero and non one-hot codes never expire
            default: limit = {CNT_W{1'b0}};
        endcase
    end

    // Expiry on the retry that brings the count to the limit
    assign expirePulse = reqActive && retryPulse && !expired_q &&
        (limit != {CNT_W{1'b0}}) && (count_q + 1'b1 == limit);
    assign retryCount = count_q;

    // ----------------------------------------------------------------
    // Counter
    // ----------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (!resetn) begin
            count_q <= {CNT_W{1'b0}};
            expired_q <= 1'b0;
        end else if (reqDone || !reqActive) begin
            count_q <= {CNT_W{1'b0}};
            expired_q <= 1'b0;
        end else if (retryPulse && !expired_q) begin
            // Saturates so a disabled limit cannot wrap
            if (count_q != {CNT_W{1'b1}}) begin
                count_q <= count_q + 1'b1;
            end
            if (expirePulse) begin
                expired_q <= 1'b1;
            end
        end
    end
endmodule

// [sec_bus_model.sv]
// Partner model: targets on the secondary bus retrying the own request.
// Assumes its tasks are called from one process, just after an edge.
`timescale 1ns/10ps
module sec_bus_model (
    input wire ref_clk,
    output reg ownReqActive,
    output reg ownRetry,
    output reg ownReqDone
);
    initial begin
        ownReqActive = 1'b0;
        ownRetry = 1'b0;
        ownReqDone = 1'b0;
    end
    // Back to back retries: the hardest case for the counter
    task retries(input int n);
        @(posedge ref_clk);
        ownReqActive <= 1'b1;
        repeat (n) begin
            @(posedge ref_clk);
            ownRetry <= 1'b1;
        end
        @(posedge ref_clk);
        ownRetry <= 1'b0;
    endtask
    task finish();
        @(posedge ref_clk);
        ownReqActive <= 1'b0;
        ownReqDone <= 1'b1;
        @(posedge ref_clk);
        ownReqDone <= 1'b0;
    endtask
endmodule

// [secondary_retry_and_arb_enables.v]
// Secondary-side retry limiter and arbiter request enables with an
// AXI4-Lite register slave.
// Assumes secondary bus events arrive as synchronous pulses on ref_clk.
//
// Functional notes
// - Count retries per own request; drop request when count reaches limit.
// - Code zero disables expiry, retry forever; zero after reset.
// - Codes 1,2,4,8 give 256, 64K, 16M, 2G retry thresholds.
// - Bit 30 admits internal requests to arbitration; resets to one.
// - Bits 29..26 enable external request lines 3..0; reset to ones.
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/10ps
`include "retry_arb_map.vh"

module secondary_retry_and_arb_enables #(
    parameter CNT_W = 32
) (
    input wire ref_clk,
    input wire resetn,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire intReqIn,
    input wire [3:0] extRequestLines,
    output wire intReqToArb,
    output wire [3:0] extReqToArb,
    input wire ownReqActive,
    input wire ownRetry,
    input wire ownReqDone,
    output reg ownReqDiscard,
    input wire npWriteDataParityErr,
    output reg parityErrorOutput,
    output reg npWriteTerminate,
    output reg npWriteEnqueueBlock
);
    reg [3:0] retryCode_q;
    reg intArbEn_q;
    reg [3:0] lineArbEn_q;
    reg retryExpired_q;
    reg parityDetected_q;
    reg awHeld_q;
    reg wHeld_q;
    reg [7:0] awAddr_q;
    reg [31:0] wData_q;
    reg [3:0] wStrb_q;
    wire expirePulse;
    wire [CNT_W-1:0] retryCount;
    wire doWrite;
    wire clrRetry;
    wire clrParity;
    wire [7:0] rdWordAddr;

    // ----------------------------------------------------------------
    // Retry limiter
    // ----------------------------------------------------------------
    // Count is full width so the 2G limit is reachable; software sees 24 bits
    retry_limiter #(
        .CNT_W(CNT_W)
    ) limiter (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .limitCode(retryCode_q),
        .reqActive(ownReqActive),
        .retryPulse(ownRetry),
        .reqDone(ownReqDone),
        .expirePulse(expirePulse),
        .retryCount(retryCount)
    );

    // ----------------------------------------------------------------
    // Arbiter request gating
    // ----------------------------------------------------------------
    assign intReqToArb = intReqIn && intArbEn_q;
    assign extReqToArb = extRequestLines & lineArbEn_q;

    // ----------------------------------------------------------------
    // Event outputs
    // ----------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (!resetn) begin
            ownReqDiscard <= 1'b0;
            parityErrorOutput <= 1'b0;
            npWriteTerminate <= 1'b0;
            npWriteEnqueueBlock <= 1'b0;
        end else begin
            ownReqDiscard <= expirePulse;
            // Fixed policy: report, terminate, never enqueue
            // A held error input repeats the pulse each cycle it stays high
            parityErrorOutput <= npWriteDataParityErr;
            npWriteTerminate <= npWriteDataParityErr;
            npWriteEnqueueBlock <= npWriteDataParityErr;
        end
    end

    // ----------------------------------------------------------------
    // AXI4-Lite write channel
    // ----------------------------------------------------------------
    // Address and data may arrive in either order; each is held once taken
    assign s_axi_awready = !awHeld_q && !s_axi_bvalid;
    assign s_axi_wready = !wHeld_q && !s_axi_bvalid;
    assign doWrite = awHeld_q && wHeld_q && !s_axi_bvalid;
    // Status clears act with the write itself, not with the response
    assign clrRetry = doWrite && (awAddr_q == `RETRY_STATUS_OFFSET) && wStrb_q[0] &&
        wData_q[0];
    assign clrParity = doWrite && (awAddr_q == `RETRY_STATUS_OFFSET) && wStrb_q[0] &&
        wData_q[1];

    always @(posedge ref_clk) begin
        if (!resetn) begin
            awHeld_q <= 1'b0;
            wHeld_q <= 1'b0;
            awAddr_q <= 8'h00;
            wData_q <= 32'h00000000;
            wStrb_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
            retryCode_q <= `RETRY_CODE_RESET;
            intArbEn_q <= `INT_ARB_EN_RESET;
            lineArbEn_q <= `LINE_ARB_EN_RESET;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld_q <= 1'b1;
                awAddr_q <= {s_axi_awaddr[7:2], 2'h0};
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld_q <= 1'b1;
                wData_q <= s_axi_wdata;
                wStrb_q <= s_axi_wstrb;
            end
            if (doWrite) begin
                awHeld_q <= 1'b0;
                wHeld_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= 2'h0;
                if (awAddr_q == `RETRY_LIMIT_OFFSET) begin
                    if (wStrb_q[0]) begin
                        retryCode_q <= wData_q[`RETRY_CODE_MSB:0];
                    end
                end else if (awAddr_q == `MISC_CTRL_OFFSET) begin
                    // Enables sit in the top byte lane; bit 24 and reserved bits ignore writes
                    if (wStrb_q[3]) begin
                        intArbEn_q <= wData_q[`INT_ARB_EN_BIT];
                        lineArbEn_q <= wData_q[`LINE_ARB_EN_MSB:`LINE_ARB_EN_LSB];
                    end
                end else if (awAddr_q != `RETRY_STATUS_OFFSET) begin
                    s_axi_bresp <= 2'h2;
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Sticky status, write one to clear; a new event wins over a clear
    // ----------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (!resetn) begin
            retryExpired_q <= 1'b0;
            parityDetected_q <= 1'b0;
        end else begin
            if (expirePulse) begin
                retryExpired_q <= 1'b1;
            end else if (clrRetry) begin
                retryExpired_q <= 1'b0;
            end
            if (npWriteDataParityErr) begin
                parityDetected_q <= 1'b1;
            end else if (clrParity) begin
                parityDetected_q <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // AXI4-Lite read channel
    // ----------------------------------------------------------------
    assign s_axi_arready = !s_axi_rvalid;
    // Low address bits ignored: every register is one aligned word
    assign rdWordAddr = {s_axi_araddr[7:2], 2'h0};

    always @(posedge ref_clk) begin
        if (!resetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'h0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'h0;
            s_axi_rdata <= 32'h00000000;
            if (rdWordAddr == `RETRY_LIMIT_OFFSET) begin
                s_axi_rdata <= {28'h0000000, retryCode_q};
            end else if (rdWordAddr == `MISC_CTRL_OFFSET) begin
                // Policy bit is fixed at one
                s_axi_rdata <= {1'b0, intArbEn_q, lineArbEn_q, 1'b0, 1'b1,
                    24'h000000};
            end else if (rdWordAddr == `RETRY_STATUS_OFFSET) begin
                // Count shown in the upper bits, truncated to 24
                s_axi_rdata <= {retryCount[23:0], 6'h00, parityDetected_q,
                    retryExpired_q};
            end else begin
                s_axi_rresp <= 2'h2;
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule

// [sra_asserts.sv]
// Checker for the retry limiter, arbiter gates and parity policy.
// Assumes binding to secondary_retry_and_arb_enables, one clock.
`timescale 1ns/10ps
module sra_asserts (
    input wire ref_clk,
    input wire resetn,
    input wire intReqIn,
    input wire intReqToArb,
    input wire [3:0] extRequestLines,
    input wire [3:0] extReqToArb,
    input wire ownReqActive,
    input wire ownRetry,
    input wire ownReqDiscard,
    input wire npWriteDataParityErr,
    input wire parityErrorOutput,
    input wire npWriteTerminate,
    input wire npWriteEnqueueBlock
);
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);
    sequence parErrIn;
        npWriteDataParityErr;
    endsequence
    sequence parErrOut;
        parityErrorOutput && npWriteTerminate && npWriteEnqueueBlock;
    endsequence
    int_gate_a: assert property (intReqToArb |-> intReqIn)
        else $error("internal request passed while idle");
    line_gate_a: assert property ((extReqToArb & ~extRequestLines) == 4'h0)
        else $error("request line passed while idle");
    gates_open_a: assert property ($rose(resetn) |->
        intReqToArb == intReqIn && extReqToArb == extRequestLines)
        else $error("gates closed after reset");
    par_resp_a: assert property (parErrIn |=> parErrOut)
        else $error("parity error not answered");
    par_cause_a: assert property (parityErrorOutput |-> $past(npWriteDataParityErr))
        else $error("parity output without cause");
    par_pair_a: assert property (npWriteTerminate |-> parErrOut)
        else $error("terminate without parity flag");
    discard_once_a: assert property (ownReqDiscard |=> !ownReqDiscard)
        else $error("discard longer than one cycle");
    discard_cause_a: assert property (ownReqDiscard |->
        $past(ownRetry) && $past(ownReqActive))
        else $error("discard without a retry");
endmodule

// [tb_top.sv]
// Testbench: registers over AXI4-Lite, arbiter gates, retry expiry, parity.
// Assumes the checker below and the partner model sec_bus_model.
`timescale 1ns/10ps
module tb_top;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic [7:0] s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h00000000;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic intReqIn = 1'b1;
    logic [3:0] extRequestLines = 4'hF;
    logic npWriteDataParityErr = 1'b0;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire intReqToArb, ownReqActive, ownRetry, ownReqDone, ownReqDiscard;
    wire parityErrorOutput, npWriteTerminate, npWriteEnqueueBlock;
    wire [3:0] extReqToArb;
    int fails = 0;
    int totalChecks = 0;
    int discards = 0;
    logic [31:0] rd;
    logic [1:0] rsp;
    secondary_retry_and_arb_enables secondary_retry_and_arb_enables_i (.ref_clk, .resetn,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .intReqIn, .extRequestLines, .intReqToArb,
        .extReqToArb, .ownReqActive, .ownRetry, .ownReqDone, .ownReqDiscard,
        .npWriteDataParityErr, .parityErrorOutput, .npWriteTerminate, .npWriteEnqueueBlock);
    sec_bus_model sec_bus_model_i (.ref_clk, .ownReqActive, .ownRetry, .ownReqDone);
    initial forever #2 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (ownReqDiscard === 1'b1) discards++;
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        totalChecks++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task end_sim();
        $display("checks %0d mismatches %0d", totalChecks, fails);
        if (fails == 0 && totalChecks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic got;
        got = 1'b0;
        @(posedge ref_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (int n = 0; n < 40 && !got; n++) begin
            @(posedge ref_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                s_axi_bready <= 1'b0;
                rsp = s_axi_bresp;
                got = 1'b1;
            end
        end
        if (!got) fails++;
        chk(rsp, er);
    endtask
    task axr(input logic [7:0] a);
        logic got;
        got = 1'b0;
        @(posedge ref_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (int n = 0; n < 40 && !got; n++) begin
            @(posedge ref_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                s_axi_rready <= 1'b0;
                rd = s_axi_rdata;
                rsp = s_axi_rresp;
                got = 1'b1;
            end
        end
        if (!got) fails++;
    endtask
    task t_reset_and_unmapped();
        axr(8'h40);
        chk(rd, 32'h00000000);
        axr(8'h44);
        chk(rd, 32'h7D000000);
        chk({intReqToArb, extReqToArb}, 32'h0000001F);
        axw(8'h80, 32'hFFFFFFFF, 2'h2);
        axr(8'h80);
        chk(rsp, 2'h2);
        chk(rd, 32'h00000000);
    endtask
    task t_arb_gates();
        axw(8'h44, 32'h14000000, 2'h0);
        chk({intReqToArb, extReqToArb}, 32'h00000005);
        extRequestLines <= 4'hA;
        @(posedge ref_clk);
        chk(extReqToArb, 4'h0);
        axr(8'h44);
        chk(rd, 32'h15000000);
        axw(8'h44, 32'h7C000000, 2'h0);
        chk({intReqToArb, extReqToArb}, 32'h0000001A);
        intReqIn <= 1'b0;
        @(posedge ref_clk);
        chk(intReqToArb, 1'b0);
        intReqIn <= 1'b1;
    endtask
    task t_retry_limit();
        axw(8'h40, 32'h00000001, 2'h0);
        sec_bus_model_i.retries(255);
        repeat (3) @(posedge ref_clk);
        chk(discards, 0);
        axr(8'h4C);
        chk(rd, 32'h0000FF00);
        sec_bus_model_i.retries(1);
        repeat (3) @(posedge ref_clk);
        chk(discards, 1);
        sec_bus_model_i.retries(8);
        sec_bus_model_i.finish();
        sec_bus_model_i.retries(255);
        sec_bus_model_i.finish();
        axw(8'h40, 32'h00000000, 2'h0);
        sec_bus_model_i.retries(300);
        sec_bus_model_i.finish();
        chk(discards, 1);
    endtask
    task t_parity();
        npWriteDataParityErr <= 1'b1;
        @(posedge ref_clk);
        npWriteDataParityErr <= 1'b0;
        @(posedge ref_clk);
        chk({parityErrorOutput, npWriteTerminate, npWriteEnqueueBlock}, 3'h7);
        @(posedge ref_clk);
        chk(parityErrorOutput, 1'b0);
        axr(8'h4C);
        chk(rd, 32'h00000003);
        axw(8'h4C, 32'h00000003, 2'h0);
        axr(8'h4C);
        chk(rd, 32'h00000000);
    endtask
    initial begin
        repeat (16) @(posedge ref_clk);
        resetn <= 1'b1;
        t_reset_and_unmapped();
        t_arb_gates();
        t_retry_limit();
        t_parity();
        end_sim();
    end
    // Whole run is about 900 cycles; this leaves wide margin
    initial begin
        #40000;
        fails++;
        end_sim();
    end
endmodule
bind secondary_retry_and_arb_enables sra_asserts sra_asserts_i (.ref_clk, .resetn, .intReqIn,
    .intReqToArb, .extRequestLines, .extReqToArb, .ownReqActive, .ownRetry, .ownReqDiscard,
    .npWriteDataParityErr, .parityErrorOutput, .npWriteTerminate, .npWriteEnqueueBlock);
